// file: logic/gim_pin_mux.sv
// Pin multiplexer, general-purpose pins, external interrupts and strap capture
`timescale 1ns/10ps
module gim_pin_mux #(
  parameter int NGPIO = 16
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output gim_pkg::gim_apb_resp_t      apb_resp,
  // General-purpose pins
  input  wire logic [NGPIO-1:0]       gp_pin_in,
  output gim_pkg::gim_gp_drive_t      gp_pin_drive,
  // Host/PCI shared pins
  input  wire logic [4:0]             hp_pin_in,
  output gim_pkg::gim_hp_drive_t      hp_pin_drive,
  // Straps and nonmaskable interrupt pin
  input  wire logic                   pci_enable_strap,
  input  wire logic                   serial2_select_strap,
  input  wire logic                   host_data_bit5_strap,
  input  wire logic                   nmi_pin,
  // Core side: host port
  input  wire logic                   host_irq_out,
  output logic                        host_reg_select_hi,
  output logic                        host_reg_select_lo,
  output logic                        host_halfword_select,
  output logic                        host_read_write_select,
  output logic                        host_port_16bit_mode,
  output logic                        host_port_32bit_mode,
  // Core side: PCI
  input  gim_pkg::gim_hp_drive_t      pci_hp_drive,
  output logic [4:0]                  pci_hp_in,
  input  wire logic                   pci_request_out,
  input  wire logic                   pci_irq_a_out,
  input  wire logic                   pci_byte_enable3_out,
  input  wire logic                   pci_byte_enable3_oe,
  output logic                        pci_byte_enable3_in,
  output logic                        pci_config_select_in,
  output logic                        pci_grant_in,
  output logic                        pci_clock_in,
  output logic                        pci_reset_in,
  // Core side: misc
  input  wire logic                   gpio_zero_irq_output,
  output logic                        serial2_ext_clock_in,
  output logic                        nmi_pulse,
  output logic [3:0]                  external_irq_line,
  output gim_pkg::gim_periph_en_t     periph_en
);

  typedef struct packed {
    logic                   nmi_s1;
    logic                   nmi_s2;
    logic                   nmi_d;
    logic [NGPIO-1:0]       gp_s1;
    logic [NGPIO-1:0]       gp_s2;
    logic [3:0]             ext_d;
    logic [4:0]             hp_s1;
    logic [4:0]             hp_s2;
    logic [2:0]             strap_s1;
    logic [2:0]             strap_s2;
    logic [1:0]             strap_cnt;
    logic                   strap_done;
    logic                   pci_mode;
    logic                   hp16;
    logic                   ser2;
    logic [15:0]            dir;
    logic [15:0]            dout;
    logic [2:0]             alt;
    logic [3:0]             irq_en;
    logic [3:0]             pol;
    gim_pkg::gim_gp0_mode_t gp0_mode;
    logic [4:0]             events;
    logic [1:0]             c4;
    logic [1:0]             c6;
    logic                   clk4;
    logic                   clk6;
    gim_pkg::gim_gp_drive_t gp_drv;
    gim_pkg::gim_hp_drive_t hp_drv;
    gim_pkg::gim_apb_resp_t resp;
    logic [3:0]             host_sig;
    logic                   hp16_o;
    logic                   hp32_o;
    logic [4:0]             pci_hp;
    logic [4:0]             pci_side;
    logic                   ser2_clk;
    logic                   nmi_p;
    logic [3:0]             ext_p;
    gim_pkg::gim_periph_en_t pen;
  } gim_state_t;

  gim_state_t st_reg;
  gim_state_t st_next;

  // Decodes whether an offset names a register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == gim_pkg::OFS_DIR) || (a == gim_pkg::OFS_DOUT) || (a == gim_pkg::OFS_DIN) ||
                (a == gim_pkg::OFS_ALT) || (a == gim_pkg::OFS_IRQ_EN) || (a == gim_pkg::OFS_POL) ||
                (a == gim_pkg::OFS_GP0) || (a == gim_pkg::OFS_STATUS) || (a == gim_pkg::OFS_EVENT);
  endfunction : is_mapped

  logic [3:0] ext_cur;
  logic [3:0] ext_prev;
  logic [3:0] ext_edge;
  logic       nmi_edge;
  logic       wr_fire;
  logic [31:0] rd_val;

  always_comb begin
    st_next = st_reg;

    //==============================================================================
    // Synchronisers: first stage feeds only the second
    st_next.nmi_s1   = nmi_pin;
    st_next.nmi_s2   = st_reg.nmi_s1;
    st_next.gp_s1    = gp_pin_in;
    st_next.gp_s2    = st_reg.gp_s1;
    st_next.hp_s1    = hp_pin_in;
    st_next.hp_s2    = st_reg.hp_s1;
    st_next.strap_s1 = {host_data_bit5_strap, serial2_select_strap, pci_enable_strap};
    st_next.strap_s2 = st_reg.strap_s1;

    //==============================================================================
    // Straps caught once the synchronisers have filled after reset
    if (!st_reg.strap_done) begin
      if (st_reg.strap_cnt == gim_pkg::STRAP_SETTLE) begin
        st_next.strap_done = 1'b1;
        st_next.pci_mode   = st_reg.strap_s2[0];
        st_next.ser2       = st_reg.strap_s2[1];
        st_next.hp16       = ~st_reg.strap_s2[2];
      end else begin
        st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      end
    end

    //==============================================================================
    // Edge detection
    nmi_edge = st_reg.nmi_s2 & ~st_reg.nmi_d;
    st_next.nmi_d = st_reg.nmi_s2;
    st_next.nmi_p = nmi_edge;
    ext_cur  = st_reg.gp_s2[gim_pkg::PIN_EXT0 +: 4] ^ st_reg.pol;
    ext_prev = st_reg.ext_d ^ st_reg.pol;
    ext_edge = ext_cur & ~ext_prev & st_reg.irq_en;
    st_next.ext_d = st_reg.gp_s2[gim_pkg::PIN_EXT0 +: 4];
    st_next.ext_p = ext_edge;

    //==============================================================================
    // Clock dividers; div6 is 3 high / 3 low to keep duty at half
    if (st_reg.c4 == gim_pkg::DIV4_HALF) begin
      st_next.c4   = 2'h0;
      st_next.clk4 = ~st_reg.clk4;
    end else begin
      st_next.c4 = st_reg.c4 + 2'h1;
    end
    if (st_reg.c6 == gim_pkg::DIV6_HALF) begin
      st_next.c6   = 2'h0;
      st_next.clk6 = ~st_reg.clk6;
    end else begin
      st_next.c6 = st_reg.c6 + 2'h1;
    end

    //==============================================================================
    // APB: one wait state, write and read data at the pready edge
    wr_fire = psel & penable & st_reg.resp.pready & pwrite;
    st_next.resp.pready  = psel & penable & ~st_reg.resp.pready;
    st_next.resp.pslverr = psel & penable & ~st_reg.resp.pready & ~is_mapped(paddr);
    rd_val = 32'h0000_0000;
    unique case (paddr)
      gim_pkg::OFS_DIR:    rd_val[15:0] = st_reg.dir;
      gim_pkg::OFS_DOUT:   rd_val[15:0] = st_reg.dout;
      gim_pkg::OFS_DIN:    rd_val[NGPIO-1:0] = st_reg.gp_s2;
      gim_pkg::OFS_ALT:    rd_val[2:0] = st_reg.alt;
      gim_pkg::OFS_IRQ_EN: rd_val[gim_pkg::IRQ_EN_HI:gim_pkg::IRQ_EN_LO] = st_reg.irq_en;
      gim_pkg::OFS_POL:    rd_val[3:0] = st_reg.pol;
      gim_pkg::OFS_GP0:    rd_val[1:0] = st_reg.gp0_mode;
      gim_pkg::OFS_STATUS: begin
        rd_val[gim_pkg::ST_PCI]  = st_reg.pci_mode;
        rd_val[gim_pkg::ST_HP16] = st_reg.hp16;
        rd_val[gim_pkg::ST_SER2] = st_reg.ser2;
        rd_val[gim_pkg::ST_DONE] = st_reg.strap_done;
      end
      gim_pkg::OFS_EVENT:  rd_val[4:0] = st_reg.events;
      default:             rd_val = 32'h0000_0000;
    endcase
    st_next.resp.prdata = (psel & penable & ~st_reg.resp.pready & ~pwrite) ? rd_val : 32'h0000_0000;

    // Sticky events: a new edge wins over a write-one-to-clear
    st_next.events = st_reg.events;
    if (wr_fire && paddr == gim_pkg::OFS_EVENT) begin
      st_next.events = st_reg.events & ~pwdata[4:0];
    end
    st_next.events = st_next.events | {ext_edge, nmi_edge};

    if (wr_fire) begin
      unique case (paddr)
        gim_pkg::OFS_DIR:    st_next.dir = pwdata[15:0];
        gim_pkg::OFS_DOUT:   st_next.dout = pwdata[15:0];
        gim_pkg::OFS_ALT:    st_next.alt = pwdata[2:0];
        gim_pkg::OFS_IRQ_EN: st_next.irq_en = pwdata[gim_pkg::IRQ_EN_HI:gim_pkg::IRQ_EN_LO];
        gim_pkg::OFS_POL:    st_next.pol = pwdata[3:0];
        gim_pkg::OFS_GP0: begin
          // Code 3 is refused: pin 0 never enters an undefined mode
          if (pwdata[1:0] != 2'b11) begin
            st_next.gp0_mode = gim_pkg::gim_gp0_mode_t'(pwdata[1:0]);
          end
        end
        default: ;
      endcase
    end

    //==============================================================================
    // General-purpose pin drive
    st_next.gp_drv.out = st_reg.dout;
    st_next.gp_drv.oe  = st_reg.dir;
    unique case (st_reg.gp0_mode)
      gim_pkg::GP0_INPUT:  st_next.gp_drv.oe[gim_pkg::PIN_GP0] = 1'b0;
      gim_pkg::GP0_OUTPUT: st_next.gp_drv.oe[gim_pkg::PIN_GP0] = 1'b1;
      gim_pkg::GP0_IRQ: begin
        st_next.gp_drv.oe[gim_pkg::PIN_GP0]  = 1'b1;
        st_next.gp_drv.out[gim_pkg::PIN_GP0] = gpio_zero_irq_output;
      end
      default: st_next.gp_drv.oe[gim_pkg::PIN_GP0] = 1'b0;
    endcase
    if (!st_reg.alt[gim_pkg::ALT_CLK4]) begin
      st_next.gp_drv.oe[gim_pkg::PIN_CLK4]  = 1'b1;
      st_next.gp_drv.out[gim_pkg::PIN_CLK4] = st_reg.clk4;
    end
    if (!st_reg.alt[gim_pkg::ALT_CLK6]) begin
      st_next.gp_drv.oe[gim_pkg::PIN_CLK6]  = 1'b1;
      st_next.gp_drv.out[gim_pkg::PIN_CLK6] = st_reg.clk6;
    end
    // Interrupt inputs never drive the pin
    for (int k = 0; k < 4; k++) begin
      if (st_reg.irq_en[k]) begin
        st_next.gp_drv.oe[gim_pkg::PIN_EXT0 + k] = 1'b0;
      end
    end
    if (!st_reg.alt[gim_pkg::ALT_SERIAL2_EXT_CLOCK_IN]) begin
      st_next.gp_drv.oe[gim_pkg::PIN_SERIAL2_EXT_CLOCK_IN] = 1'b0;
    end
    st_next.ser2_clk = ~st_reg.alt[gim_pkg::ALT_SERIAL2_EXT_CLOCK_IN] & st_reg.gp_s2[gim_pkg::PIN_SERIAL2_EXT_CLOCK_IN];

    // PCI takes pins 9 to 15 only once the strap says so
    if (st_reg.pci_mode) begin
      st_next.gp_drv.oe[gim_pkg::PIN_PCI_HI:gim_pkg::PIN_PCI_LO] = 7'h00;
      st_next.gp_drv.out[gim_pkg::PIN_CBE3] = pci_byte_enable3_out;
      st_next.gp_drv.oe[gim_pkg::PIN_CBE3]  = pci_byte_enable3_oe;
      st_next.gp_drv.out[gim_pkg::PIN_REQ]  = pci_request_out;
      st_next.gp_drv.oe[gim_pkg::PIN_REQ]   = 1'b1;
      // Interrupt A is open drain: pulled low while asserted
      st_next.gp_drv.out[gim_pkg::PIN_INTA] = 1'b0;
      st_next.gp_drv.oe[gim_pkg::PIN_INTA]  = pci_irq_a_out;
    end
    st_next.pci_side = st_reg.pci_mode ?
      {st_reg.gp_s2[gim_pkg::PIN_PCI_RESET_IN], st_reg.gp_s2[gim_pkg::PIN_PCLK], st_reg.gp_s2[gim_pkg::PIN_GNT],
       st_reg.gp_s2[gim_pkg::PIN_IDSEL], st_reg.gp_s2[gim_pkg::PIN_CBE3]} : 5'h00;

    //==============================================================================
    // Host/PCI shared pins
    if (st_reg.pci_mode) begin
      st_next.hp_drv   = pci_hp_drive;
      st_next.pci_hp   = st_reg.hp_s2;
      st_next.host_sig = 4'h0;
    end else begin
      st_next.hp_drv.out = 5'h00;
      st_next.hp_drv.oe  = 5'h00;
      st_next.hp_drv.out[gim_pkg::HP_IRQ] = host_irq_out;
      st_next.hp_drv.oe[gim_pkg::HP_IRQ]  = 1'b1;
      st_next.pci_hp   = 5'h00;
      st_next.host_sig = {st_reg.hp_s2[gim_pkg::HP_RW], st_reg.hp_s2[gim_pkg::HP_HALF] & st_reg.hp16,
                          st_reg.hp_s2[gim_pkg::HP_SELL], st_reg.hp_s2[gim_pkg::HP_SELH]};
    end
    st_next.hp16_o = st_reg.strap_done & ~st_reg.pci_mode & st_reg.hp16;
    st_next.hp32_o = st_reg.strap_done & ~st_reg.pci_mode & ~st_reg.hp16;

    // Peripheral enables
    st_next.pen.host_port = st_reg.strap_done & ~st_reg.pci_mode;
    st_next.pen.gpio_hi   = st_reg.strap_done & ~st_reg.pci_mode;
    st_next.pen.pci       = st_reg.strap_done & st_reg.pci_mode;
    st_next.pen.serial2   = st_reg.strap_done & st_reg.ser2;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.dir      <= gim_pkg::DIR_RST;
      st_reg.dout     <= gim_pkg::DOUT_RST;
      st_reg.alt      <= gim_pkg::ALT_RST;
      st_reg.pol      <= gim_pkg::POL_RST;
      st_reg.gp0_mode <= gim_pkg::GP0_INPUT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_resp               = st_reg.resp;
  assign gp_pin_drive           = st_reg.gp_drv;
  assign hp_pin_drive           = st_reg.hp_drv;
  assign host_reg_select_hi     = st_reg.host_sig[0];
  assign host_reg_select_lo     = st_reg.host_sig[1];
  assign host_halfword_select   = st_reg.host_sig[2];
  assign host_read_write_select = st_reg.host_sig[3];
  assign host_port_16bit_mode   = st_reg.hp16_o;
  assign host_port_32bit_mode   = st_reg.hp32_o;
  assign pci_hp_in              = st_reg.pci_hp;
  assign pci_byte_enable3_in    = st_reg.pci_side[0];
  assign pci_config_select_in   = st_reg.pci_side[1];
  assign pci_grant_in           = st_reg.pci_side[2];
  assign pci_clock_in           = st_reg.pci_side[3];
  assign pci_reset_in           = st_reg.pci_side[4];
  assign serial2_ext_clock_in   = st_reg.ser2_clk;
  assign nmi_pulse              = st_reg.nmi_p;
  assign external_irq_line      = st_reg.ext_p;
  assign periph_en              = st_reg.pen;

endmodule : gim_pin_mux

// file: logic/gim_pkg.sv
// Constants, register map and carrier types for the pin mux and general-purpose pin block
//==============================================================================
// Function
// - A rising edge on the nonmaskable interrupt input gives one pulse; level never retriggers.
// - Pins 4 to 7 reset to general-purpose inputs with drivers off.
// - Enable bits 7..4 turn pins 4 to 7 into edge-triggered external interrupts.
// - Polarity bits 3..0 pick the active edge of each external interrupt.
// - Pins 9 to 15 are general-purpose or PCI signals; nothing active by default.
// - Pin 3 has no alternate function and resets as an input.
// - Pin 0 is input (default), output, or is driven by the internal general-purpose interrupt.
// - Pin 8 defaults to serial port 2 clock input, may become general-purpose.
// - Pin 2 defaults to a clock at one sixth core rate, may become general-purpose.
// - Pin 1 defaults to a clock at one quarter core rate, may become general-purpose.
// - PCI strap picks host port plus pins 9 to 15, or PCI; low means host port.
// - PCI strap and serial-port-2 strap together decide the other peripheral enables.
// - Host mode drives the host interrupt pin; PCI mode makes it the frame pin.
// - Host port width is latched from data bit 5 strap: low 16-bit, high 32-bit.
package gim_pkg;

  //==============================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DIR     = 8'h00;
  localparam logic [7:0] OFS_DOUT    = 8'h04;
  localparam logic [7:0] OFS_DIN     = 8'h08;
  localparam logic [7:0] OFS_ALT     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_POL     = 8'h14;
  localparam logic [7:0] OFS_GP0     = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_EVENT   = 8'h20;

  //==============================================================================
  // Field positions and reset values
  localparam int IRQ_EN_LO = 4;
  localparam int IRQ_EN_HI = 7;
  localparam int ALT_CLK4  = 0;
  localparam int ALT_CLK6  = 1;
  localparam int ALT_SERIAL2_EXT_CLOCK_IN = 2;
  localparam int ST_PCI    = 0;
  localparam int ST_HP16   = 1;
  localparam int ST_SER2   = 2;
  localparam int ST_DONE   = 3;
  localparam logic [15:0] DIR_RST  = 16'h0000;
  localparam logic [15:0] DOUT_RST = 16'h0000;
  localparam logic [2:0]  ALT_RST  = 3'h0;
  localparam logic [3:0]  POL_RST  = 4'h0;

  //==============================================================================
  // Pin indices
  localparam int PIN_GP0   = 0;
  localparam int PIN_CLK4  = 1;
  localparam int PIN_CLK6  = 2;
  localparam int PIN_EXT0  = 4;
  localparam int PIN_SERIAL2_EXT_CLOCK_IN = 8;
  localparam int PIN_IDSEL = 9;
  localparam int PIN_CBE3  = 10;
  localparam int PIN_REQ   = 11;
  localparam int PIN_GNT   = 12;
  localparam int PIN_INTA  = 13;
  localparam int PIN_PCLK  = 14;
  localparam int PIN_PCI_RESET_IN  = 15;
  localparam int PIN_PCI_LO = 9;
  localparam int PIN_PCI_HI = 15;

  // Host/PCI shared pins
  localparam int HP_IRQ  = 0;
  localparam int HP_SELH = 1;
  localparam int HP_SELL = 2;
  localparam int HP_HALF = 3;
  localparam int HP_RW   = 4;

  //==============================================================================
  // Clock divider half periods and strap settle time
  localparam logic [1:0] DIV4_HALF    = 2'h1;
  localparam logic [1:0] DIV6_HALF    = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    GP0_INPUT  = 2'b00,
    GP0_OUTPUT = 2'b01,
    GP0_IRQ    = 2'b10
  } gim_gp0_mode_t;

  //==============================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } gim_gp_drive_t;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } gim_hp_drive_t;

  typedef struct packed {
    logic host_port;
    logic pci;
    logic serial2;
    logic gpio_hi;
  } gim_periph_en_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } gim_apb_resp_t;

endpackage : gim_pkg

// file: verification/gim_far_model.sv
// Far-side model: external host and pin drivers, with wire resolution
`timescale 1ns/10ps
module gim_far_model (
  // Clock
  input wire logic              clock,
  // Device drives
  input gim_pkg::gim_gp_drive_t gp_pin_drive,
  input gim_pkg::gim_hp_drive_t hp_pin_drive,
  // Far-side levels and enables
  input wire logic [15:0]       gp_ext,
  input wire logic [15:0]       gp_ext_en,
  input wire logic [4:0]        hp_ext,
  input wire logic [4:0]        hp_ext_en,
  // Resolved pin levels
  output logic [15:0]           gp_pin_in,
  output logic [4:0]            hp_pin_in
);
  logic [4:0] hp_last = 5'h00;
  // Undriven pins fall to the pull-down
  assign gp_pin_in = gp_pin_drive.oe & gp_pin_drive.out | ~gp_pin_drive.oe & gp_ext_en & gp_ext;
  // Released host lines flip each cycle so stale levels show
  assign hp_pin_in = hp_pin_drive.oe & hp_pin_drive.out
                   | ~hp_pin_drive.oe & (hp_ext_en & hp_ext | ~hp_ext_en & ~hp_last);
  always @(posedge clock) hp_last <= hp_pin_in;
endmodule : gim_far_model

// file: verification/gim_pin_mux_props.sv
// Assertion checker for the pin mux block
`timescale 1ns/10ps
module gim_pin_mux_props (
  // Clock and reset
  input wire logic               clock,
  input wire logic               rst,
  // Watched ports
  input gim_pkg::gim_gp_drive_t  gp_pin_drive,
  input wire logic               nmi_pin,
  input wire logic               nmi_pulse,
  input wire logic [3:0]         external_irq_line,
  input wire logic [4:0]         pci_hp_in,
  input wire logic               pci_grant_in,
  input wire logic               host_reg_select_hi,
  input wire logic               host_port_16bit_mode,
  input wire logic               host_port_32bit_mode,
  input wire logic               host_data_bit5_strap,
  input wire logic               serial2_select_strap,
  input gim_pkg::gim_periph_en_t periph_en
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ======
  // Properties
  property p_nmi_edge;
    $rose(nmi_pin) |-> ##[2:6] nmi_pulse;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge gave no pulse");
  property p_nmi_single;
    nmi_pulse |=> !nmi_pulse;
  endproperty
  a_nmi_single: assert property (p_nmi_single) else $error("nmi pulse retriggered");
  property p_ext_single;
    (|external_irq_line) |=> (external_irq_line & $past(external_irq_line)) == 4'h0;
  endproperty
  a_ext_single: assert property (p_ext_single) else $error("external irq held");
  property p_reset_dirs;
    $fell(rst) |-> gp_pin_drive.oe[15:3] == 13'h0000 && !gp_pin_drive.oe[0];
  endproperty
  a_reset_dirs: assert property (p_reset_dirs) else $error("pin driven after reset");
  property p_pci_quiet;
    !periph_en.pci |-> pci_hp_in == 5'h00 && !pci_grant_in;
  endproperty
  a_pci_quiet: assert property (p_pci_quiet) else $error("pci input leaks");
  property p_host_quiet;
    periph_en.pci && $past(periph_en.pci) |-> !host_reg_select_hi && !host_port_16bit_mode && !host_port_32bit_mode;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("host input leaks");
  property p_periph;
    periph_en.pci || periph_en.host_port |-> periph_en.host_port == !periph_en.pci
      && periph_en.gpio_hi == periph_en.host_port && periph_en.serial2 == serial2_select_strap;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral enables wrong");
  property p_width;
    host_port_16bit_mode || host_port_32bit_mode |->
      host_port_32bit_mode == host_data_bit5_strap && host_port_16bit_mode != host_port_32bit_mode;
  endproperty
  a_width: assert property (p_width) else $error("host width wrong");
  c_nmi: cover property (nmi_pulse);
  c_ext: cover property (|external_irq_line);
  c_pci: cover property (periph_en.pci);
endmodule : gim_pin_mux_props

bind gim_pin_mux gim_pin_mux_props u_props (.*);

// file: verification/gim_pin_mux_tb_top.sv
// Testbench for the pin mux block
`timescale 1ns/10ps
module gim_pin_mux_tb_top;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } gim_row_t;
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pci_enable_strap = 1'b0, serial2_select_strap = 1'b1, host_data_bit5_strap = 1'b0;
  logic        nmi_pin = 1'b0, host_irq_out = 1'b0, gpio_zero_irq_output = 1'b0, pci_req = 1'b1;
  logic [15:0] gp_ext = 16'h0000, gp_ext_en = 16'h0000, gp_pin_in, last_out;
  logic [4:0]  hp_ext = 5'h00, hp_ext_en = 5'h00, hp_pin_in, pci_hp_in;
  logic        host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_read_write_select;
  logic        host_port_16bit_mode, host_port_32bit_mode, serial2_ext_clock_in, nmi_pulse, pci_grant_in;
  logic        pci_byte_enable3_in, pci_config_select_in, pci_clock_in, pci_reset_in;
  logic [3:0]  external_irq_line;
  gim_pkg::gim_hp_drive_t  pci_hp_drive = 10'h000, hp_pin_drive;
  gim_pkg::gim_apb_resp_t  apb_resp;
  gim_pkg::gim_gp_drive_t  gp_pin_drive;
  gim_pkg::gim_periph_en_t periph_en;
  int          err_total = 0, n_checks = 0, nmi_cnt = 0, s0, s1;
  int          tog [2];
  int          ext_cnt [4];
  gim_row_t    rows [9] = '{
    '{1'b0, gim_pkg::OFS_DIR, {16'h0000, gim_pkg::DIR_RST}, 1'b0},
    '{1'b0, gim_pkg::OFS_DOUT, {16'h0000, gim_pkg::DOUT_RST}, 1'b0},
    '{1'b0, gim_pkg::OFS_ALT, {29'h0, gim_pkg::ALT_RST}, 1'b0},
    '{1'b0, gim_pkg::OFS_IRQ_EN, 32'h0000_0000, 1'b0},
    '{1'b0, gim_pkg::OFS_POL, {28'h0, gim_pkg::POL_RST}, 1'b0},
    '{1'b0, gim_pkg::OFS_GP0, 32'h0000_0000, 1'b0},
    '{1'b1, gim_pkg::OFS_STATUS, 32'h0000_00FF, 1'b0},
    '{1'b0, gim_pkg::OFS_STATUS, 32'h0000_000E, 1'b0},
    '{1'b0, 8'h24, 32'h0000_0000, 1'b1}
  };

  gim_pin_mux u_dut (
    .pci_request_out(pci_req), .pci_irq_a_out(1'b0), .pci_byte_enable3_out(1'b0), .pci_byte_enable3_oe(1'b0), .*
  );
  gim_far_model u_far (.*);

  // ======
  // Clock and counters
  always #5 clock = ~clock;
  always @(posedge clock) begin
    last_out <= gp_pin_drive.out;
    for (int k = 0; k < 2; k++) tog[k] <= tog[k] + (gp_pin_drive.out[k+1] != last_out[k+1]);
    nmi_cnt <= nmi_cnt + nmi_pulse;
    for (int k = 0; k < 4; k++) ext_cnt[k] <= ext_cnt[k] + external_irq_line[k];
  end

  // ======
  // Tasks
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(negedge clock);
      n++;
    end while (apb_resp.pready !== 1'b1 && n < 16);
    chk(apb_resp.pready === 1'b1 && apb_resp.pslverr === e && (w || apb_resp.prdata === d), "apb response");
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ======
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    tick(6);
    foreach (rows[i]) xfer(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    gp_ext_en <= 16'h0100;
    gp_ext <= 16'h0100;
    s0 = tog[0];
    s1 = tog[1];
    tick(24);
    chk(tog[0] - s0 == 12 && tog[1] - s1 == 8, "divided clock rate");
    chk(gp_pin_drive.oe[2:1] === 2'b11 && serial2_ext_clock_in === 1'b1, "default pin functions");
    xfer(1'b1, gim_pkg::OFS_ALT, 32'h0000_0007, 1'b0);
    xfer(1'b1, gim_pkg::OFS_DIR, 32'h0000_0102, 1'b0);
    xfer(1'b1, gim_pkg::OFS_DOUT, 32'h0000_0103, 1'b0);
    gp_ext_en <= 16'h0000;
    tick(4);
    s0 = tog[0];
    tick(8);
    chk(serial2_ext_clock_in === 1'b0 && tog[0] == s0, "alternate not released");
    chk(gp_pin_drive.oe[8:1] === 8'h81 && gp_pin_drive.out[8:1] === 8'h81, "general pins");
    xfer(1'b0, gim_pkg::OFS_DIN, 32'h0000_0102, 1'b0);
    xfer(1'b1, gim_pkg::OFS_GP0, 32'h0000_0001, 1'b0);
    tick(3);
    chk(gp_pin_drive.oe[0] === 1'b1 && gp_pin_drive.out[0] === 1'b1, "pin 0 output");
    gpio_zero_irq_output <= 1'b1;
    xfer(1'b1, gim_pkg::OFS_GP0, 32'h0000_0002, 1'b0);
    xfer(1'b1, gim_pkg::OFS_DOUT, 32'h0000_0102, 1'b0);
    tick(3);
    chk(gp_pin_drive.oe[0] === 1'b1 && gp_pin_drive.out[0] === 1'b1, "pin 0 irq high");
    gpio_zero_irq_output <= 1'b0;
    tick(3);
    chk(gp_pin_drive.out[0] === 1'b0, "pin 0 irq low");
    xfer(1'b1, gim_pkg::OFS_GP0, 32'h0000_0003, 1'b0);
    xfer(1'b0, gim_pkg::OFS_GP0, 32'h0000_0002, 1'b0);
    s0 = nmi_cnt;
    nmi_pin <= 1'b1;
    tick(20);
    chk(nmi_cnt - s0 == 1, "nmi pulse count");
    xfer(1'b0, gim_pkg::OFS_EVENT, 32'h0000_0001, 1'b0);
    xfer(1'b1, gim_pkg::OFS_EVENT, 32'h0000_0001, 1'b0);
    nmi_pin <= 1'b0;
    gp_ext_en <= 16'h00F0;
    gp_ext <= 16'h0010;
    tick(10);
    chk(ext_cnt[0] == 0, "disabled irq fired");
    gp_ext <= 16'h0000;
    xfer(1'b1, gim_pkg::OFS_IRQ_EN, 32'h0000_00F0, 1'b0);
    xfer(1'b1, gim_pkg::OFS_POL, 32'h0000_0002, 1'b0);
    xfer(1'b1, gim_pkg::OFS_DIR, 32'h0000_00F0, 1'b0);
    gp_ext <= 16'h0030;
    tick(10);
    chk(ext_cnt[0] == 1 && ext_cnt[1] == 0 && gp_pin_drive.oe[7:4] === 4'h0, "rising edges");
    gp_ext <= 16'h0000;
    tick(10);
    chk(ext_cnt[0] == 1 && ext_cnt[1] == 1, "falling edge");
    xfer(1'b0, gim_pkg::OFS_EVENT, 32'h0000_0006, 1'b0);
    hp_ext_en <= 5'h1E;
    hp_ext <= 5'h1E;
    host_irq_out <= 1'b1;
    tick(4);
    chk({host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_read_write_select} === 4'hF
        && periph_en === 4'hB, "host selects high");
    chk(hp_pin_drive.oe[0] === 1'b1 && hp_pin_drive.out[0] === 1'b1, "host irq high");
    host_irq_out <= 1'b0;
    hp_ext <= 5'h0A;
    tick(4);
    chk({host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_read_write_select} === 4'hA
        && hp_pin_drive.out[0] === 1'b0, "host selects mixed");
    // Second reset with the PCI strap set
    pci_enable_strap <= 1'b1;
    host_data_bit5_strap <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    pci_hp_drive <= 10'h084;
    gp_ext_en <= 16'h1000;
    gp_ext <= 16'h1000;
    hp_ext_en <= 5'h02;
    hp_ext <= 5'h02;
    tick(8);
    xfer(1'b0, gim_pkg::OFS_STATUS, 32'h0000_000D, 1'b0);
    chk(pci_grant_in === 1'b1 && pci_hp_in[1] === 1'b1 && host_reg_select_hi === 1'b0, "pci inputs");
    chk(hp_pin_drive.oe === 5'h04 && hp_pin_drive.out[2] === 1'b1 && periph_en === 4'h6, "pci drive");
    chk(gp_pin_drive.oe[11] === 1'b1 && gp_pin_drive.out[11] === 1'b1, "pci request");
    final_report();
  end

  initial begin
    #300000;
    err_total++;
    final_report();
  end
endmodule : gim_pin_mux_tb_top
